// ==== core/ofd_pkg.sv ====
// Purpose: Shared constants and types of the output frequency detector
// Assumes: Frequency in 0.01 Hz steps, current in 0.1 A, delay in 0.1 s
// Notes:   Offsets are byte addresses on the plain register port
package ofd_pkg;
    // ----------------------------------------
    // Widths and timing
    // ----------------------------------------
    localparam int FW = 16;
    localparam int CW = 14;
    localparam int DW = 7;
    localparam int IW = 4;
    localparam longint CLK_HZ  = 125_000_000;
    localparam longint UNIT_MS = 100;
    localparam longint OFF_MS  = 100;
    localparam int unsigned TICK_CYC = 32'(UNIT_MS * CLK_HZ / 1000);
    localparam logic [DW-1:0] OFF_UNITS = DW'(OFF_MS / UNIT_MS);

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] A_SEL  = 8'h00;
    localparam logic [7:0] A_THR  = 8'h0C;
    localparam logic [7:0] A_CUR  = 8'h24;
    localparam logic [7:0] A_DLY  = 8'h28;
    localparam logic [7:0] A_STAT = 8'h2C;
    localparam logic [7:0] A_IRQ  = 8'h30;
    localparam logic [7:0] A_MASK = 8'h34;
    localparam logic [3:0] I_SEL  = 4'(A_SEL >> 2);
    localparam logic [3:0] I_THR  = 4'(A_THR >> 2);
    localparam logic [3:0] I_CUR  = 4'(A_CUR >> 2);
    localparam logic [3:0] I_DLY  = 4'(A_DLY >> 2);
    localparam logic [3:0] I_STAT = 4'(A_STAT >> 2);
    localparam logic [3:0] I_IRQ  = 4'(A_IRQ >> 2);
    localparam logic [3:0] I_MASK = 4'(A_MASK >> 2);
    localparam logic [3:0] I_NONE = 4'hF;

    localparam logic [7:0]    SEL_RST = 8'h00;
    localparam logic [FW-1:0] THR_RST = 16'h0000;
    localparam logic [CW-1:0] CUR_MIN = 14'h0001;
    localparam logic [CW-1:0] CUR_MAX = 14'h270F;
    localparam logic [DW-1:0] DLY_MIN = 7'h01;
    localparam logic [DW-1:0] DLY_MAX = 7'h64;
    localparam logic [IW-1:0] MASK_RST = 4'h0;

    // ----------------------------------------
    // Output function codes
    // ----------------------------------------
    localparam logic [7:0] FN_RUN   = 8'h01;
    localparam logic [7:0] FN_D1R   = 8'h04;
    localparam logic [7:0] FN_D1F   = 8'h05;
    localparam logic [7:0] FN_CUR   = 8'h0D;
    localparam logic [7:0] FN_CRANE = 8'h27;
    localparam logic [7:0] FN_D2R   = 8'h32;
    localparam logic [7:0] FN_D2F   = 8'h33;
    localparam logic [7:0] FN_D3R   = 8'h34;
    localparam logic [7:0] FN_D3F   = 8'h35;

    typedef struct packed {
        logic [FW-1:0] level;
        logic [FW-1:0] width;
    } ofd_thr_t;
    typedef struct packed {
        logic [FW-1:0] freq;
        logic [CW-1:0] cur;
        logic          run;
        logic          upd;
    } ofd_meas_t;
    typedef struct packed {
        logic [2:0] rise;
        logic [2:0] fall;
        logic       crane;
        logic       run;
        logic       cur;
    } ofd_flags_t;
endpackage : ofd_pkg

// ==== core/ofd_hyst.sv ====
// Purpose: One level/width pair, rising and falling type flags
// Assumes: upd marks a fresh frequency sample on the same clock
// Notes:   Falling type is a window flag, rising type has hysteresis
`timescale 1ns/1ns
module ofd_hyst (
    input  logic                   sys_clk,
    input  logic                   reset,
    input  logic                   upd,
    input  logic [ofd_pkg::FW-1:0] freq,
    input  ofd_pkg::ofd_thr_t      thr,
    output logic                   rise,
    output logic                   fall
);
    logic [ofd_pkg::FW:0] top_w;
    logic [ofd_pkg::FW:0] lvl_w;
    logic [ofd_pkg::FW:0] f_w;
    logic rise_reg;
    logic rise_next;
    logic fall_reg;
    logic fall_next;

    // Widened so level plus width cannot wrap
    assign top_w = {1'b0, thr.level} + {1'b0, thr.width};
    assign lvl_w = {1'b0, thr.level};
    assign f_w   = {1'b0, freq};

    always_comb begin
        rise_next = rise_reg;
        fall_next = fall_reg;
        if (upd) begin
            if (f_w > top_w) begin
                rise_next = 1'b1;
            end else if (f_w < lvl_w) begin
                rise_next = 1'b0;
            end
            fall_next = (f_w >= lvl_w) && (f_w < top_w);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            rise_reg <= rise_next;
            fall_reg <= fall_next;
        end
    end

    assign rise = rise_reg;
    assign fall = fall_reg;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rise_set;
        upd && (f_w > top_w) |=> rise_reg;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rise flag not set");
    property p_rise_hold;
        (upd && (f_w >= lvl_w) && (f_w <= top_w)) or !upd |=> $stable(rise_reg);
    endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("rise flag moved in band");
    property p_fall_clr;
        upd && (f_w < lvl_w) |=> !fall_reg;
    endproperty
    a_fall_clr: assert property (p_fall_clr) else $error("fall flag not cleared");
endmodule : ofd_hyst

// ==== core/ofd_agree.sv ====
// Purpose: Current agreement output with on delay and fixed off delay
// Assumes: above is a same-clock level, dly is in delay units
// Notes:   A dip of the condition restarts the pending wait
`timescale 1ns/1ns
module ofd_agree #(
    parameter int unsigned TICK_CYC = ofd_pkg::TICK_CYC
) (
    input  logic                   sys_clk,
    input  logic                   reset,
    input  logic                   above,
    input  logic [ofd_pkg::DW-1:0] dly,
    output logic                   active
);
    localparam int SW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
    if (TICK_CYC < 1) begin : g_bad_tick
        $error("TICK_CYC must be at least one");
    end

    typedef enum logic [3:0] {
        S_OFF  = 4'b0001,
        S_ONW  = 4'b0010,
        S_ACT  = 4'b0100,
        S_OFFW = 4'b1000
    } ofd_agree_st_t;

    ofd_agree_st_t          st_reg;
    ofd_agree_st_t          st_next;
    logic [SW-1:0]          sub_reg;
    logic [SW-1:0]          sub_next;
    logic [ofd_pkg::DW-1:0] unit_reg;
    logic [ofd_pkg::DW-1:0] unit_next;
    logic                   active_reg;
    logic                   wrap;

    assign wrap = (sub_reg == SW'(TICK_CYC - 1));

    always_comb begin
        st_next   = st_reg;
        sub_next  = sub_reg + 1'b1;
        unit_next = unit_reg;
        if (wrap) begin
            sub_next  = '0;
            unit_next = unit_reg + 1'b1;
        end
        case (st_reg)
            S_OFF: begin
                sub_next  = '0;
                unit_next = '0;
                if (above) begin
                    st_next = S_ONW;
                end
            end
            S_ONW: begin
                if (!above) begin
                    st_next = S_OFF;
                end else if (wrap && (unit_next >= dly)) begin
                    st_next = S_ACT;
                end
            end
            S_ACT: begin
                sub_next  = '0;
                unit_next = '0;
                if (!above) begin
                    st_next = S_OFFW;
                end
            end
            S_OFFW: begin
                if (above) begin
                    st_next = S_ACT;
                end else if (wrap && (unit_next >= ofd_pkg::OFF_UNITS)) begin
                    st_next = S_OFF;
                end
            end
            default: begin
                st_next = S_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_reg     <= S_OFF;
            sub_reg    <= '0;
            unit_reg   <= '0;
            active_reg <= 1'b0;
        end else begin
            st_reg     <= st_next;
            sub_reg    <= sub_next;
            unit_reg   <= unit_next;
            active_reg <= (st_next == S_ACT) || (st_next == S_OFFW);
        end
    end

    assign active = active_reg;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_on_cause;
        $rose(active_reg) |-> $past(above) && $past(wrap) && ($past(unit_next) >= $past(dly));
    endproperty
    a_on_cause: assert property (p_on_cause) else $error("agree on without delay");
    property p_off_time;
        $fell(active_reg) |-> $past(wrap) && !$past(above);
    endproperty
    a_off_time: assert property (p_off_time) else $error("agree off too early");
    c_agree_on: cover property ($rose(active_reg));
endmodule : ofd_agree

// ==== core/ofd_freq_detect.sv ====
// Purpose: Output frequency and current agreement detector of a drive
// Assumes: meas comes from the control logic on sys_clk, upd once per update
// Notes:   Three outputs each pick one flag by function code
//
// How it works
// - Code 5: pair one falling-type window flag
// - Code 50: pair two rising flag
// - Code 51: pair two falling-type window flag
// - Code 52: pair three rising flag
// - Code 53: pair three falling-type window flag
// - Crane flag sets accelerating above top
// - Crane flag clears decelerating below level
// - Code 39 routes crane flag to output
// - Running function follows drive output activity
// - Agree level and delay held in range
// - Agree output after delay when current exceeds
// - Agree output releases after fixed 100 ms
// - Code 4: pair one rising flag
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module ofd_freq_detect #(
    parameter int unsigned TICK_CYC = ofd_pkg::TICK_CYC
) (
    input  logic              sys_clk,
    input  logic              reset,
    input  logic [7:0]        reg_addr,
    input  logic [31:0]       reg_wdata,
    input  logic              reg_wr,
    input  logic              reg_rd,
    output logic [31:0]       reg_rdata,
    input  ofd_pkg::ofd_meas_t meas,
    output logic [2:0]        dout,
    output logic              irq
);
    // One tick must last at least a clock, else no delay unit can elapse
    if (TICK_CYC < 1) begin : g_bad_tick
        $error("TICK_CYC must be at least one");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] idx_of(input logic [7:0] a);
        if ((a[1:0] != 2'b00) || (a > ofd_pkg::A_MASK)) begin
            return ofd_pkg::I_NONE;
        end
        return a[5:2];
    endfunction : idx_of

    function automatic logic pick(input logic [7:0] code, input ofd_pkg::ofd_flags_t f);
        case (code)
            ofd_pkg::FN_D1R:   return f.rise[0];
            ofd_pkg::FN_D1F:   return f.fall[0];
            ofd_pkg::FN_D2R:   return f.rise[1];
            ofd_pkg::FN_D2F:   return f.fall[1];
            ofd_pkg::FN_D3R:   return f.rise[2];
            ofd_pkg::FN_D3F:   return f.fall[2];
            ofd_pkg::FN_CRANE: return f.crane;
            ofd_pkg::FN_RUN:   return f.run;
            ofd_pkg::FN_CUR:   return f.cur;
            default:           return 1'b0;
        endcase
    endfunction : pick

    // Out of range writes snap to the nearest end rather than being dropped
    function automatic logic [ofd_pkg::CW-1:0] clamp_cur(input logic [31:0] v);
        if (v < 32'(ofd_pkg::CUR_MIN)) return ofd_pkg::CUR_MIN;
        if (v > 32'(ofd_pkg::CUR_MAX)) return ofd_pkg::CUR_MAX;
        return v[ofd_pkg::CW-1:0];
    endfunction : clamp_cur

    function automatic logic [ofd_pkg::DW-1:0] clamp_dly(input logic [31:0] v);
        if (v < 32'(ofd_pkg::DLY_MIN)) return ofd_pkg::DLY_MIN;
        if (v > 32'(ofd_pkg::DLY_MAX)) return ofd_pkg::DLY_MAX;
        return v[ofd_pkg::DW-1:0];
    endfunction : clamp_dly

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [2:0][7:0]               sel_reg;
    logic [2:0][7:0]               sel_next;
    ofd_pkg::ofd_thr_t [2:0]       thr_reg;
    ofd_pkg::ofd_thr_t [2:0]       thr_next;
    logic [ofd_pkg::CW-1:0]        cur_reg;
    logic [ofd_pkg::CW-1:0]        cur_next;
    logic [ofd_pkg::DW-1:0]        dly_reg;
    logic [ofd_pkg::DW-1:0]        dly_next;
    logic [ofd_pkg::IW-1:0]        ist_reg;
    logic [ofd_pkg::IW-1:0]        ist_next;
    logic [ofd_pkg::IW-1:0]        mask_reg;
    logic [ofd_pkg::IW-1:0]        mask_next;
    logic [31:0]                   rdata_reg;
    logic [31:0]                   rdata_next;
    logic [ofd_pkg::FW-1:0]        prev_reg;
    logic [ofd_pkg::FW-1:0]        prev_next;
    logic                          crane_reg;
    logic                          crane_next;
    logic [2:0]                    dout_reg;
    logic [2:0]                    dout_next;
    logic                          agree_q_reg;
    logic                          irq_reg;
    logic                          irq_next;
    logic [2:0]                    rise_w;
    logic [2:0]                    fall_w;
    logic                          agree_w;
    logic [ofd_pkg::FW:0]          top1_w;
    logic [ofd_pkg::IW-1:0]        ev_w;
    logic [ofd_pkg::IW-1:0]        clr_w;
    logic [3:0]                    widx;
    logic [3:0]                    ridx;
    ofd_pkg::ofd_flags_t           flags;

    // ----------------------------------------
    // Threshold pairs and current agreement
    // ----------------------------------------
    for (genvar k = 0; k < 3; k++) begin : g_pair
        ofd_hyst u_hyst (
            .sys_clk (sys_clk),
            .reset   (reset),
            .upd     (meas.upd),
            .freq    (meas.freq),
            .thr     (thr_reg[k]),
            .rise    (rise_w[k]),
            .fall    (fall_w[k])
        );
    end

    ofd_agree #(
        .TICK_CYC (TICK_CYC)
    ) u_agree (
        .sys_clk (sys_clk),
        .reset   (reset),
        .above   (meas.cur > cur_reg),
        .dly     (dly_reg),
        .active  (agree_w)
    );

    assign top1_w = {1'b0, thr_reg[0].level} + {1'b0, thr_reg[0].width};

    always_comb begin
        flags       = '0;
        flags.rise  = rise_w;
        flags.fall  = fall_w;
        flags.crane = crane_reg;
        flags.run   = meas.run;
        flags.cur   = agree_w;
    end

    // ----------------------------------------
    // Crane flag and output routing
    // ----------------------------------------
    always_comb begin
        prev_next  = prev_reg;
        crane_next = crane_reg;
        if (meas.upd) begin
            prev_next = meas.freq;
            if ((meas.freq > prev_reg) && ({1'b0, meas.freq} > top1_w)) begin
                crane_next = 1'b1;
            end else if ((meas.freq < prev_reg) && (meas.freq < thr_reg[0].level)) begin
                crane_next = 1'b0;
            end
        end
        for (int k = 0; k < 3; k++) begin
            dout_next[k] = pick(sel_reg[k], flags);
        end
    end

    // ----------------------------------------
    // Register port and interrupt
    // ----------------------------------------
    assign widx = idx_of(reg_addr);
    assign ridx = widx;
    assign ev_w = {agree_w & ~agree_q_reg, dout_next & ~dout_reg};

    always_comb begin
        sel_next   = sel_reg;
        thr_next   = thr_reg;
        cur_next   = cur_reg;
        dly_next   = dly_reg;
        mask_next  = mask_reg;
        clr_w      = '0;
        rdata_next = 32'h0000_0000;
        if (reg_wr) begin
            for (int k = 0; k < 3; k++) begin
                if (widx == 4'(ofd_pkg::I_SEL + k)) sel_next[k] = reg_wdata[7:0];
                if (widx == 4'(ofd_pkg::I_THR + 2 * k)) thr_next[k].level = reg_wdata[15:0];
                if (widx == 4'(ofd_pkg::I_THR + 2 * k + 1)) thr_next[k].width = reg_wdata[15:0];
            end
            case (widx)
                ofd_pkg::I_CUR:  cur_next = clamp_cur(reg_wdata);
                ofd_pkg::I_DLY:  dly_next = clamp_dly(reg_wdata);
                ofd_pkg::I_IRQ:  clr_w = reg_wdata[ofd_pkg::IW-1:0];
                ofd_pkg::I_MASK: mask_next = reg_wdata[ofd_pkg::IW-1:0];
                default: ;
            endcase
        end
        // A new event wins over a clear in the same cycle
        ist_next = (ist_reg & ~clr_w) | ev_w;
        irq_next = |(ist_next & mask_next);
        if (reg_rd) begin
            for (int k = 0; k < 3; k++) begin
                if (ridx == 4'(ofd_pkg::I_SEL + k)) rdata_next = {24'h00_0000, sel_reg[k]};
                if (ridx == 4'(ofd_pkg::I_THR + 2 * k)) rdata_next = {16'h0000, thr_reg[k].level};
                if (ridx == 4'(ofd_pkg::I_THR + 2 * k + 1)) rdata_next = {16'h0000, thr_reg[k].width};
            end
            case (ridx)
                ofd_pkg::I_CUR:  rdata_next = {18'h0_0000, cur_reg};
                ofd_pkg::I_DLY:  rdata_next = {25'h000_0000, dly_reg};
                ofd_pkg::I_STAT: rdata_next = {21'h00_0000, fall_w, rise_w, agree_w, crane_reg, dout_reg};
                ofd_pkg::I_IRQ:  rdata_next = {28'h000_0000, ist_reg};
                ofd_pkg::I_MASK: rdata_next = {28'h000_0000, mask_reg};
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sel_reg     <= {3{ofd_pkg::SEL_RST}};
            thr_reg     <= {6{ofd_pkg::THR_RST}};
            cur_reg     <= ofd_pkg::CUR_MIN;
            dly_reg     <= ofd_pkg::DLY_MIN;
            ist_reg     <= '0;
            mask_reg    <= ofd_pkg::MASK_RST;
            rdata_reg   <= 32'h0000_0000;
            prev_reg    <= '0;
            crane_reg   <= 1'b0;
            dout_reg    <= 3'h0;
            agree_q_reg <= 1'b0;
            irq_reg     <= 1'b0;
        end else begin
            sel_reg     <= sel_next;
            thr_reg     <= thr_next;
            cur_reg     <= cur_next;
            dly_reg     <= dly_next;
            ist_reg     <= ist_next;
            mask_reg    <= mask_next;
            rdata_reg   <= rdata_next;
            prev_reg    <= prev_next;
            crane_reg   <= crane_next;
            dout_reg    <= dout_next;
            agree_q_reg <= agree_w;
            irq_reg     <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign dout      = dout_reg;
    assign irq       = irq_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_fall1;
        sel_reg[1] == ofd_pkg::FN_D1F |=> dout_reg[1] == $past(fall_w[0]);
    endproperty
    a_fall1: assert property (p_fall1) else $error("fall flag one not routed");
    property p_rise3;
        sel_reg[0] == ofd_pkg::FN_D3R |=> dout_reg[0] == $past(rise_w[2]);
    endproperty
    a_rise3: assert property (p_rise3) else $error("rise flag three not routed");
    property p_crane_set;
        meas.upd && (meas.freq > prev_reg) && ({1'b0, meas.freq} > top1_w) |=> crane_reg;
    endproperty
    a_crane_set: assert property (p_crane_set) else $error("crane flag not set");
    property p_crane_clr;
        meas.upd && (meas.freq < prev_reg) && (meas.freq < thr_reg[0].level) |=> !crane_reg;
    endproperty
    a_crane_clr: assert property (p_crane_clr) else $error("crane flag not cleared");
    property p_crane_route;
        sel_reg[2] == ofd_pkg::FN_CRANE |=> dout_reg[2] == $past(crane_reg);
    endproperty
    a_crane_route: assert property (p_crane_route) else $error("crane flag not routed");
    property p_run;
        sel_reg[2] == ofd_pkg::FN_RUN ##1 sel_reg[2] == ofd_pkg::FN_RUN |-> dout_reg[2] == $past(meas.run);
    endproperty
    a_run: assert property (p_run) else $error("running output wrong");
    property p_range;
        (cur_reg >= ofd_pkg::CUR_MIN) && (cur_reg <= ofd_pkg::CUR_MAX)
            && (dly_reg >= ofd_pkg::DLY_MIN) && (dly_reg <= ofd_pkg::DLY_MAX);
    endproperty
    a_range: assert property (p_range) else $error("agree setting out of range");
    property p_steady;
        meas.upd && (meas.freq == prev_reg) |=> $stable(crane_reg);
    endproperty
    a_steady: assert property (p_steady) else $error("crane flag moved when steady");
    property p_irq;
        (|(ev_w & mask_next)) |=> irq_reg;
    endproperty
    a_irq: assert property (p_irq) else $error("event lost on interrupt");

    c_crane: cover property ($rose(crane_reg) ##[1:200] $fell(crane_reg));
    c_irq: cover property ($rose(irq_reg));
    c_clr_event: cover property (reg_wr && (widx == ofd_pkg::I_IRQ) && (|ev_w));
    c_agree_out: cover property ((sel_reg[0] == ofd_pkg::FN_CUR) && $rose(dout_reg[0]));

    property p_rdata_idle;
        !reg_rd |=> rdata_reg == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule : ofd_freq_detect

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench of the output frequency detector
// Assumes: TICK_CYC shortened to 8 cycles, so one delay unit is 8 cycles
// Notes:   Each scenario task drives the block and judges the result itself
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
    logic               sys_clk;
    logic               reset;
    logic [7:0]         reg_addr;
    logic [31:0]        reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [31:0]        reg_rdata;
    ofd_pkg::ofd_meas_t meas;
    logic [2:0]         dout;
    logic               irq;
    logic [31:0]        d;
    int                 fail_count;
    int                 checked;

    ofd_freq_detect #(.TICK_CYC(8)) dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .meas(meas), .dout(dout), .irq(irq));

    // ----------------------------------------
    // Bus and sample drivers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        `CHK(d, e)
    endtask : rdc
    // Flags move one cycle after the update edge, outputs one more
    task automatic samp(input logic [15:0] f);
        @(posedge sys_clk);
        meas.freq <= f;
        meas.upd  <= 1'b1;
        @(posedge sys_clk);
        meas.upd <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : samp
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_n

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rdc(ofd_pkg::A_CUR, 32'h0000_0001);
        rdc(ofd_pkg::A_DLY, 32'h0000_0001);
        rdc(ofd_pkg::A_MASK, 32'h0000_0000);
        rdc(8'h3C, 32'h0000_0000);
        wr(ofd_pkg::A_STAT, 32'h0000_FFFF);
        rdc(ofd_pkg::A_STAT, 32'h0000_0000);
        wr(ofd_pkg::A_CUR, 32'h0000_0000);
        rdc(ofd_pkg::A_CUR, 32'h0000_0001);
        wr(ofd_pkg::A_CUR, 32'h0000_FFFF);
        rdc(ofd_pkg::A_CUR, 32'h0000_270F);
        wr(ofd_pkg::A_DLY, 32'h0000_007F);
        rdc(ofd_pkg::A_DLY, 32'h0000_0064);
    endtask : t_regs
    task automatic t_pairs;
        logic [7:0]  rc [3] = '{ofd_pkg::FN_D1R, ofd_pkg::FN_D2R, ofd_pkg::FN_D3R};
        logic [7:0]  fc [3] = '{ofd_pkg::FN_D1F, ofd_pkg::FN_D2F, ofd_pkg::FN_D3F};
        logic [15:0] lv;
        for (int k = 0; k < 3; k++) begin
            lv = 16'(1000 * (k + 1));
            wr(8'(ofd_pkg::A_THR + 8 * k), 32'(lv));
            wr(8'(ofd_pkg::A_THR + 8 * k + 4), 32'h0000_0064);
            wr(ofd_pkg::A_SEL, 32'(rc[k]));
            wr(8'h04, 32'(fc[k]));
            samp(lv + 16'd101);
            `CHK(dout[1:0], 2'b01)
            samp(lv + 16'd50);
            `CHK(dout[1:0], 2'b11)
            samp(lv - 16'd1);
            `CHK(dout[1:0], 2'b00)
            samp(lv + 16'd50);
            `CHK(dout[1:0], 2'b10)
            samp(lv + 16'd100);
            `CHK(dout[1:0], 2'b00)
        end
    endtask : t_pairs
    task automatic t_irq;
        `CHK(irq, 1'b0)
        rdc(ofd_pkg::A_IRQ, 32'h0000_0003);
        wr(ofd_pkg::A_IRQ, 32'h0000_000F);
        rdc(ofd_pkg::A_IRQ, 32'h0000_0000);
        wr(ofd_pkg::A_MASK, 32'h0000_0001);
        samp(16'd3101);
        wait_n(1);
        `CHK(irq, 1'b1)
        wr(ofd_pkg::A_IRQ, 32'h0000_0001);
        wait_n(2);
        `CHK(irq, 1'b0)
    endtask : t_irq
    task automatic t_crane;
        logic [15:0] fq [6] = '{16'd500, 16'd1101, 16'd1050, 16'd1050, 16'd999, 16'd1050};
        logic        ex [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        wr(8'h08, 32'(ofd_pkg::FN_CRANE));
        for (int i = 0; i < 6; i++) begin
            samp(fq[i]);
            `CHK(dout[2], ex[i])
        end
    endtask : t_crane
    task automatic t_run;
        wr(8'h08, 32'(ofd_pkg::FN_RUN));
        @(posedge sys_clk);
        meas.run <= 1'b1;
        wait_n(3);
        `CHK(dout[2], 1'b1)
        @(posedge sys_clk);
        meas.run <= 1'b0;
        wait_n(3);
        `CHK(dout[2], 1'b0)
    endtask : t_run
    // One delay unit is 8 cycles here; release also takes one unit
    task automatic t_agree;
        wr(ofd_pkg::A_SEL, 32'(ofd_pkg::FN_CUR));
        wr(ofd_pkg::A_CUR, 32'h0000_000A);
        wr(ofd_pkg::A_DLY, 32'h0000_0001);
        @(posedge sys_clk);
        meas.cur <= 14'd11;
        wait_n(6);
        `CHK(dout[0], 1'b0)
        wait_n(10);
        `CHK(dout[0], 1'b1)
        @(posedge sys_clk);
        meas.cur <= 14'd5;
        wait_n(5);
        `CHK(dout[0], 1'b1)
        wait_n(10);
        `CHK(dout[0], 1'b0)
    endtask : t_agree

    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        reset      = 1'b1;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0000_0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        meas       = '0;
        fail_count = 0;
        checked    = 0;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_pairs();
        t_irq();
        t_crane();
        t_run();
        t_agree();
        conclude();
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule : tb_top
